// *** design/cad_defs.vh ***
// Constants for the carry, accumulator and auxiliary register datapath
`ifndef CAD_DEFS_VH
`define CAD_DEFS_VH

// ---------------------------------------------------------------
// Operation codes on op_code_i
// ---------------------------------------------------------------
`define CAD_OP_W        5
`define CAD_OP_NOP      5'h00
`define CAD_OP_LOAD     5'h01
`define CAD_OP_ADD      5'h02
`define CAD_OP_SUB      5'h03
`define CAD_OP_ADDH     5'h04
`define CAD_OP_SUBH     5'h05
`define CAD_OP_AND      5'h06
`define CAD_OP_OR       5'h07
`define CAD_OP_XOR      5'h08
`define CAD_OP_SHL1     5'h09
`define CAD_OP_SHR1     5'h0a
`define CAD_OP_RTL1     5'h0b
`define CAD_OP_RTR1     5'h0c
`define CAD_OP_SETCY    5'h0d
`define CAD_OP_CLRCY    5'h0e
`define CAD_OP_LSTC     5'h0f
`define CAD_OP_STH      5'h10
`define CAD_OP_STL      5'h11
`define CAD_OP_STAR     5'h12
`define CAD_OP_LAR      5'h13
`define CAD_OP_LARP     5'h14

// ---------------------------------------------------------------
// Operand and load sources
// ---------------------------------------------------------------
`define CAD_SRC_DATA    2'h0
`define CAD_SRC_PROD    2'h1
`define CAD_SRC_AUX     2'h2
`define CAD_SRC_ACC     2'h2
`define CAD_SRC_IMM     2'h3

// ---------------------------------------------------------------
// Auto-index modes of the address unit
// ---------------------------------------------------------------
`define CAD_IND_NONE    2'h0
`define CAD_IND_INC     2'h1
`define CAD_IND_DEC     2'h2
`define CAD_IND_STEP    2'h3

// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define CAD_CARRY_RST   1'b1
`define CAD_ST1_C_BIT   9
`define CAD_HI_SHIFT    16

`endif

// *** design/cad_datapath.v ***
// Carry flag, accumulator, store shifter and auxiliary register datapath
`timescale 1ns/1ns
`include "cad_defs.vh"

module cad_datapath #(
   parameter AR_NUM = 8,
   // Count width for extra shift iterations; caps the repeat length
   // A wider count only costs a few flops in the issue logic
   parameter REP_W  = 8
) (
   // Clock, reset and clock enable
   input  wire                 core_clk_i,
   input  wire                 rst_b_i,
   input  wire                 clk_en_i,
   // Operation request from the sequencer
   input  wire                 op_valid_i,
   input  wire [4:0]           op_code_i,
   input  wire [REP_W-1:0]     op_repeat_i,
   input  wire [1:0]           op_src_i,
   input  wire [3:0]           op_shift_i,
   input  wire [2:0]           store_shift_i,
   input  wire                 sign_extension_mode_i,
   output reg                  op_ready_o,
   // Operands
   input  wire [15:0]          operand_i,
   input  wire [31:0]          product_holder_i,
   input  wire [15:0]          status_word_i,
   input  wire [15:0]          imm_i,
   // Auxiliary register control
   input  wire [2:0]           ar_sel_i,
   input  wire                 ind_i,
   input  wire [1:0]           ind_mod_i,
   // Datapath state
   output reg  [31:0]          acc_o,
   output reg                  carry_o,
   output reg                  cond_c_o,
   output reg                  cond_nc_o,
   output reg  [2:0]           aux_pointer_o,
   output reg  [15:0]          mem_addr_o,
   // Store to data memory
   output reg  [15:0]          store_data_o,
   output reg                  store_valid_o
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   reg  [15:0]          ar [0:AR_NUM-1];
   wire [15:0]          next_ar [0:AR_NUM-1];
   reg                  busy;
   reg  [4:0]           hold_op;
   // Iterations owed by a repeated shift or rotate after the current one
   reg  [REP_W-1:0]     rep_left;
   reg  [4:0]           eff_op;
   reg                  go;
   reg                  take;
   reg                  is_shift;
   reg  [31:0]          sext;
   reg  [31:0]          opnd;
   reg  [32:0]          sum;
   reg  [32:0]          diff;
   reg  [32:0]          sumh;
   reg  [32:0]          diffh;
   reg  [31:0]          stw;
   reg  [15:0]          ld_val;
   reg  [15:0]          mod_val;
   reg  [31:0]          next_acc;
   reg                  next_carry;
   // Next-state values, all settled before the enabled edge
   reg  [2:0]           next_ptr;
   reg                  next_busy;
   reg  [REP_W-1:0]     next_rep;
   reg  [15:0]          next_store;
   reg                  next_svalid;
   wire [15:0]          ar_cur;
   wire                 lar_go;

   assign ar_cur = ar[aux_pointer_o];
   assign lar_go = go && (eff_op == `CAD_OP_LAR);

   // ------------------------------------------------------------
   // Issue and repeat control
   // ------------------------------------------------------------
   // While repeating, the held code runs and new requests wait.
   // Only the code is held: other operation inputs are read live,
   // so the sequencer must keep the mode bit steady during a run.
   // Holding every field would cost a wide shadow register, yet of all
   // the fields the single-bit shifts read only the mode bit.
   always @* begin
      take     = op_valid_i && !busy;
      eff_op   = busy ? hold_op : op_code_i;
      go       = busy || take;
      // Only the four single-bit accumulator moves may repeat
      is_shift = (eff_op == `CAD_OP_SHL1) || (eff_op == `CAD_OP_SHR1) ||
                 (eff_op == `CAD_OP_RTL1) || (eff_op == `CAD_OP_RTR1);
      // Default: hold the repeat state
      next_busy = busy;
      next_rep  = rep_left;
      if (busy) begin
         // One single-bit step per iteration
         // The last step runs with the count at zero
         if (rep_left == {REP_W{1'b0}}) begin
            next_busy = 1'b0;
         end else begin
            next_rep = rep_left - {{(REP_W-1){1'b0}}, 1'b1};
         end
      end else if (take && is_shift &&
                   (op_repeat_i != {REP_W{1'b0}})) begin
         // First step runs now; count what remains after it
         next_busy = 1'b1;
         next_rep  = op_repeat_i - {{(REP_W-1){1'b0}}, 1'b1};
      end
   end

   // ------------------------------------------------------------
   // Operand formation and adders
   // ------------------------------------------------------------
   // Sign extension follows the mode bit for data operands.
   always @* begin
      sext = sign_extension_mode_i ? {{16{operand_i[15]}}, operand_i}
                                   : {16'h0000, operand_i};
      case (op_src_i)
         `CAD_SRC_DATA: opnd = sext << op_shift_i;
         `CAD_SRC_PROD: opnd = product_holder_i;
         `CAD_SRC_AUX:  opnd = {16'h0000, ar_cur};
         default:       opnd = {16'h0000, imm_i};
      endcase
      sum   = {1'b0, acc_o} + {1'b0, opnd};
      diff  = {1'b0, acc_o} - {1'b0, opnd};
      // High-half forms take the operand sixteen places up
      sumh  = {1'b0, acc_o} + {1'b0, operand_i, 16'h0000};
      diffh = {1'b0, acc_o} - {1'b0, operand_i, 16'h0000};
   end

   // ------------------------------------------------------------
   // Accumulator and carry
   // ------------------------------------------------------------
   always @* begin
      next_acc   = acc_o;
      next_carry = carry_o;
      if (go) begin
         case (eff_op)
            // Loads and logic leave carry alone
            `CAD_OP_LOAD: next_acc = opnd;
            `CAD_OP_AND:  next_acc = acc_o & opnd;
            `CAD_OP_OR:   next_acc = acc_o | opnd;
            `CAD_OP_XOR:  next_acc = acc_o ^ opnd;
            `CAD_OP_ADD: begin
               next_acc   = sum[31:0];
               next_carry = sum[32];
            end
            `CAD_OP_SUB: begin
               next_acc   = diff[31:0];
               next_carry = ~diff[32];
            end
            `CAD_OP_ADDH: begin
               next_acc = sumh[31:0];
               if (sumh[32]) begin
                  next_carry = 1'b1;
               end
            end
            `CAD_OP_SUBH: begin
               next_acc = diffh[31:0];
               if (diffh[32]) begin
                  next_carry = 1'b0;
               end
            end
            // Single-bit moves pass through carry, so a repeated
            // run builds a multi-bit shift with the last bit out
            // left in carry for extended-precision chaining.
            `CAD_OP_SHL1: begin
               next_acc   = {acc_o[30:0], 1'b0};
               next_carry = acc_o[31];
            end
            `CAD_OP_SHR1: begin
               // Top bit from sign or zero by mode
               next_acc   = {sign_extension_mode_i & acc_o[31],
                             acc_o[31:1]};
               next_carry = acc_o[0];
            end
            // Rotates are 33 bits wide, carry being the extra bit
            `CAD_OP_RTL1: begin
               next_acc   = {acc_o[30:0], carry_o};
               next_carry = acc_o[31];
            end
            `CAD_OP_RTR1: begin
               next_acc   = {carry_o, acc_o[31:1]};
               next_carry = acc_o[0];
            end
            // Direct carry writes leave the accumulator alone
            `CAD_OP_SETCY: next_carry = 1'b1;
            `CAD_OP_CLRCY: next_carry = 1'b0;
            `CAD_OP_LSTC:
               next_carry = status_word_i[`CAD_ST1_C_BIT];
            default: next_acc = acc_o;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Store path with post-scaling shifter
   // ------------------------------------------------------------
   // Only the bus copy is shifted; the accumulator is untouched.
   always @* begin
      stw         = acc_o << store_shift_i;
      next_store  = store_data_o;
      next_svalid = 1'b0;
      if (go) begin
         case (eff_op)
            `CAD_OP_STH: begin
               next_store  = stw[31:16];
               next_svalid = 1'b1;
            end
            `CAD_OP_STL: begin
               next_store  = stw[15:0];
               next_svalid = 1'b1;
            end
            `CAD_OP_STAR: begin
               next_store  = ar[ar_sel_i];
               next_svalid = 1'b1;
            end
            default: next_svalid = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Auxiliary register load value and pointer
   // ------------------------------------------------------------
   always @* begin
      case (op_src_i)
         `CAD_SRC_DATA: ld_val = operand_i;
         `CAD_SRC_PROD: ld_val = product_holder_i[15:0];
         `CAD_SRC_ACC:  ld_val = acc_o[15:0];
         default:       ld_val = imm_i;
      endcase
      // Pointer holds unless loaded; only the low bits are used,
      // so a wide load value simply wraps onto the eight entries
      next_ptr = aux_pointer_o;
      if (go && (eff_op == `CAD_OP_LARP)) begin
         next_ptr = ld_val[2:0];
      end
   end

   // ------------------------------------------------------------
   // Address unit auto-index
   // ------------------------------------------------------------
   // Step register is entry zero, read before any update.
   always @* begin
      case (ind_mod_i)
         `CAD_IND_INC:  mod_val = ar_cur + 16'h0001;
         `CAD_IND_DEC:  mod_val = ar_cur - 16'h0001;
         `CAD_IND_STEP: mod_val = ar_cur + ar[0];
         default:       mod_val = ar_cur;
      endcase
   end

   // A direct load wins over auto-index on the same entry.
   genvar g;
   generate
      for (g = 0; g < AR_NUM; g = g + 1) begin : gen_ar
         assign next_ar[g] =
            (lar_go && (ar_sel_i == g)) ? ld_val :
            (ind_i && (aux_pointer_o == g)) ? mod_val :
            ar[g];
      end
   endgenerate

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   // Clock enable low freezes everything, outputs included.
   integer i;
   always @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_o         <= 32'h00000000;
         carry_o       <= `CAD_CARRY_RST;
         cond_c_o      <= `CAD_CARRY_RST;
         cond_nc_o     <= ~`CAD_CARRY_RST;
         aux_pointer_o <= 3'h0;
         mem_addr_o    <= 16'h0000;
         store_data_o  <= 16'h0000;
         store_valid_o <= 1'b0;
         op_ready_o    <= 1'b1;
         busy          <= 1'b0;
         hold_op       <= `CAD_OP_NOP;
         rep_left      <= {REP_W{1'b0}};
         for (i = 0; i < AR_NUM; i = i + 1) begin
            ar[i] <= 16'h0000;
         end
      end else if (clk_en_i) begin
         acc_o         <= next_acc;
         carry_o       <= next_carry;
         // Both senses kept as flops for the condition decoder
         cond_c_o      <= next_carry;
         cond_nc_o     <= ~next_carry;
         aux_pointer_o <= next_ptr;
         // Store pulse lasts one enabled cycle only
         store_data_o  <= next_store;
         store_valid_o <= next_svalid;
         // Ready is the registered inverse of busy, so it drops
         // in the cycle right after a repeated shift is taken
         busy          <= next_busy;
         op_ready_o    <= ~next_busy;
         rep_left      <= next_rep;
         if (take) begin
            hold_op <= op_code_i;
         end
         for (i = 0; i < AR_NUM; i = i + 1) begin
            ar[i] <= next_ar[i];
         end
         // Address shows the updated entry from the next cycle on
         // Follows a pointer load and an index update together
         mem_addr_o <= next_ar[next_ptr];
      end
   end

endmodule

// *** dv/cad_datapath_monitor.sv ***
// Port checks for the carry, accumulator and aux datapath
`timescale 1ns/1ns
`include "cad_defs.vh"
module cad_datapath_monitor #(
   parameter REP_W = 8
) (
   // Clock and reset
   input wire             core_clk_i,
   input wire             rst_b_i,
   // Requests
   input wire             clk_en_i,
   input wire             op_valid_i,
   input wire [4:0]       op_code_i,
   input wire [REP_W-1:0] op_repeat_i,
   input wire [2:0]       store_shift_i,
   input wire             sign_extension_mode_i,
   input wire [15:0]      status_word_i,
   input wire             ind_i,
   input wire [1:0]       ind_mod_i,
   // Results
   input wire             op_ready_o,
   input wire [31:0]      acc_o,
   input wire             carry_o,
   input wire             cond_c_o,
   input wire             cond_nc_o,
   input wire [15:0]      mem_addr_o,
   input wire [15:0]      store_data_o,
   input wire             store_valid_o
);
   // Operation taken at this edge
   wire take = clk_en_i & op_valid_i & op_ready_o;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_cond_follow: assert property (
      cond_c_o == carry_o && cond_nc_o == !carry_o)
      else $error("condition outputs disagree with carry");
   a_direct_write: assert property (
      take && op_code_i inside {`CAD_OP_SETCY, `CAD_OP_CLRCY}
      |=> carry_o == ($past(op_code_i) == `CAD_OP_SETCY))
      else $error("set or clear carry missed");
   a_status_load: assert property (
      take && op_code_i == `CAD_OP_LSTC
      |=> carry_o == $past(status_word_i[`CAD_ST1_C_BIT]))
      else $error("status load carry wrong");
   a_high_add: assert property (
      take && op_code_i == `CAD_OP_ADDH |=> carry_o || !$past(carry_o))
      else $error("high add cleared carry");
   a_high_sub: assert property (
      take && op_code_i == `CAD_OP_SUBH |=> !carry_o || $past(carry_o))
      else $error("high subtract set carry");
   a_logic_keep: assert property (
      take && op_code_i inside {`CAD_OP_AND, `CAD_OP_OR, `CAD_OP_XOR,
      `CAD_OP_LOAD} |=> $stable(carry_o))
      else $error("logic or load changed carry");
   a_left_shift: assert property (
      take && op_code_i == `CAD_OP_SHL1 |=> carry_o == $past(acc_o[31])
      && acc_o == {$past(acc_o[30:0]), 1'b0})
      else $error("left shift wrong");
   a_right_shift: assert property (
      take && op_code_i == `CAD_OP_SHR1 |=> carry_o == $past(acc_o[0])
      && acc_o == {$past(sign_extension_mode_i) & $past(acc_o[31]),
      $past(acc_o[31:1])})
      else $error("right shift wrong");
   a_low_store: assert property (
      take && op_code_i == `CAD_OP_STL |=> store_valid_o && $stable(acc_o)
      && store_data_o == ($past(acc_o[15:0]) << $past(store_shift_i)))
      else $error("low store wrong");
   a_high_store: assert property (
      take && op_code_i == `CAD_OP_STH |=> store_valid_o
      && store_data_o == ($past(acc_o) << $past(store_shift_i)) >> 16)
      else $error("high store wrong");
   a_repeat_two: assert property (
      take && op_code_i == `CAD_OP_SHR1 && op_repeat_i == 2
      |=> !op_ready_o [*2] ##1 op_ready_o)
      else $error("repeat busy length wrong");
   a_index_inc: assert property (
      clk_en_i && ind_i && ind_mod_i == `CAD_IND_INC && !(op_valid_i &&
      op_code_i inside {`CAD_OP_LAR, `CAD_OP_LARP})
      |=> mem_addr_o == $past(mem_addr_o) + 16'h1)
      else $error("auto increment wrong");
endmodule
bind cad_datapath cad_datapath_monitor #(.REP_W(REP_W)) i_mon (
   .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en_i),
   .op_valid_i(op_valid_i), .op_code_i(op_code_i),
   .op_repeat_i(op_repeat_i), .store_shift_i(store_shift_i),
   .sign_extension_mode_i(sign_extension_mode_i),
   .status_word_i(status_word_i), .ind_i(ind_i), .ind_mod_i(ind_mod_i),
   .op_ready_o(op_ready_o), .acc_o(acc_o), .carry_o(carry_o),
   .cond_c_o(cond_c_o), .cond_nc_o(cond_nc_o), .mem_addr_o(mem_addr_o),
   .store_data_o(store_data_o), .store_valid_o(store_valid_o));

// *** dv/cad_mem_model.sv ***
// Data memory stand-in: address-derived read words, store tally
`timescale 1ns/1ns
module cad_mem_model (
   // From the datapath
   input  wire        core_clk_i,
   input  wire [15:0] mem_addr_i,
   input  wire        store_valid_i,
   // To the datapath and bench
   output wire [15:0] operand_o,
   output reg  [31:0] store_cnt_o
);
   // Word changes with every address, so stale addresses show up
   assign operand_o = (mem_addr_i * 16'h9e37) ^ 16'h5a5a;
   // Counts store pulses; a stuck pulse inflates it
   initial store_cnt_o = 32'h0;
   always @(posedge core_clk_i) begin
      if (store_valid_i) begin
         store_cnt_o <= store_cnt_o + 32'h1;
      end
   end
endmodule

// *** dv/cad_datapath_tb_top.sv ***
// Self-checking bench for the carry, accumulator and aux datapath
`timescale 1ns/1ns
`include "cad_defs.vh"
module cad_datapath_tb_top;
   // Stimulus and observed signals
   reg         clk, rst_b, en, vld, sem, ind;
   reg  [4:0]  code, oc;
   reg  [7:0]  rep;
   reg  [1:0]  src, imod;
   reg  [3:0]  sh;
   reg  [2:0]  ssh, sel, m_p;
   reg  [15:0] stw, imm, m_sd, d;
   reg  [31:0] prod, m_acc, r, w, u;
   reg  [32:0] t;
   reg  [15:0] m_ar [0:7];
   reg         m_cy, skip;
   wire        rdy, cy, cc, nc, sv;
   wire [31:0] acc, scnt;
   wire [15:0] addr, sd, opnd;
   wire [2:0]  ptr;
   integer     err_count, samples_checked, m_scnt, seed, it, k, j;
   cad_datapath #(.AR_NUM(8), .REP_W(8)) i_cad_datapath (
      .core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(en),
      .op_valid_i(vld), .op_code_i(code), .op_repeat_i(rep),
      .op_src_i(src), .op_shift_i(sh), .store_shift_i(ssh),
      .sign_extension_mode_i(sem), .op_ready_o(rdy), .operand_i(opnd),
      .product_holder_i(prod), .status_word_i(stw), .imm_i(imm),
      .ar_sel_i(sel), .ind_i(ind), .ind_mod_i(imod), .acc_o(acc),
      .carry_o(cy), .cond_c_o(cc), .cond_nc_o(nc), .aux_pointer_o(ptr),
      .mem_addr_o(addr), .store_data_o(sd), .store_valid_o(sv));
   cad_mem_model i_cad_mem_model (.core_clk_i(clk), .mem_addr_i(addr),
      .store_valid_i(sv), .operand_o(opnd), .store_cnt_o(scnt));
   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Count and report one comparison
   task cmp(input [8*5:1] nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // Architectural state against the model
   task check_all;
      begin
         if (!skip) begin
            cmp("acc", m_acc, acc);
         end
         cmp("cy", {31'h0, m_cy}, {31'h0, cy});
         cmp("cc", {31'h0, m_cy}, {31'h0, cc});
         cmp("nc", {31'h0, ~m_cy}, {31'h0, nc});
         cmp("ptr", {29'h0, m_p}, {29'h0, ptr});
         cmp("addr", {16'h0, m_ar[m_p]}, {16'h0, addr});
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d errors %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask
   // Six-cycle reset, model back to power-up values
   task do_reset;
      begin
         @(posedge clk);
         rst_b <= 1'b0;
         repeat (6) @(posedge clk);
         rst_b <= 1'b1;
         m_acc = 32'h0;
         m_cy = 1'b1;
         m_p = 3'h0;
         skip = 1'b0;
         for (j = 0; j < 8; j = j + 1) m_ar[j] = 16'h0;
         #1;
         check_all;
         cmp("sv", 32'h0, {31'h0, sv});
      end
   endtask
   // One operation with random fields, then model and compare
   task do_op(input [4:0] c, input [1:0] s);
      begin
         r = $random(seed);
         w = $random(seed);
         @(posedge clk);
         code <= c;
         src <= s;
         vld <= 1'b1;
         sem <= r[0];
         sh <= r[4:1];
         ssh <= r[7:5];
         sel <= r[10:8];
         imod <= r[12:11];
         ind <= r[13] & (s != `CAD_SRC_IMM);
         rep <= {6'h0, r[15:14]};
         stw <= r[31:16];
         imm <= w[15:0];
         prod <= $random(seed);
         @(posedge clk);
         vld <= 1'b0;
         ind <= 1'b0;
         // Operand read at the address before any auto-index
         d = 16'h5a5a ^ (m_ar[m_p] * 16'h9e37);
         w = {{16{d[15] & r[0]}}, d} << r[4:1];
         u = m_acc << r[7:5];
         skip = 1'b0;
         case (c)
            `CAD_OP_LOAD: m_acc = prod;
            `CAD_OP_ADD: {m_cy, m_acc} = {1'b0, m_acc} + {1'b0, w};
            `CAD_OP_SUB: {m_cy, m_acc} = {1'b1, m_acc} - {1'b0, w};
            `CAD_OP_ADDH: begin
               t = {1'b0, m_acc} + {1'b0, d, 16'h0};
               m_acc = t[31:0];
               m_cy = m_cy | t[32];
            end
            `CAD_OP_SUBH: begin
               t = {1'b0, m_acc} - {1'b0, d, 16'h0};
               m_acc = t[31:0];
               m_cy = m_cy & ~t[32];
            end
            `CAD_OP_AND: m_acc = m_acc & w;
            `CAD_OP_OR: m_acc = m_acc | w;
            `CAD_OP_XOR: m_acc = m_acc ^ w;
            `CAD_OP_SHL1, `CAD_OP_SHR1, `CAD_OP_RTL1, `CAD_OP_RTR1: begin
               for (j = 0; j <= r[15:14]; j = j + 1) begin
                  case (c)
                     `CAD_OP_SHL1: {m_cy, m_acc} = {m_acc, 1'b0};
                     `CAD_OP_SHR1: {m_acc, m_cy} = {r[0] & m_acc[31], m_acc};
                     `CAD_OP_RTL1: {m_cy, m_acc} = {m_acc, m_cy};
                     default: {m_acc, m_cy} = {m_cy, m_acc};
                  endcase
               end
            end
            `CAD_OP_SETCY: m_cy = 1'b1;
            `CAD_OP_CLRCY: m_cy = 1'b0;
            `CAD_OP_LSTC: m_cy = r[16 + `CAD_ST1_C_BIT];
            `CAD_OP_STH: m_sd = u[31:16];
            `CAD_OP_STL: m_sd = u[15:0];
            `CAD_OP_STAR: m_sd = m_ar[r[10:8]];
            `CAD_OP_LAR: m_ar[r[10:8]] = imm;
            `CAD_OP_LARP: m_p = imm[2:0];
            default: ;
         endcase
         // Auto-index lands after the access
         if (r[13] && s != `CAD_SRC_IMM) begin
            case (r[12:11])
               2'h1: m_ar[m_p] = m_ar[m_p] + 16'h1;
               2'h2: m_ar[m_p] = m_ar[m_p] - 16'h1;
               2'h3: m_ar[m_p] = m_ar[m_p] + m_ar[0];
               default: ;
            endcase
         end
         #1;
         k = 0;
         while (rdy !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k = k + 1;
         end
         u = (c >= `CAD_OP_SHL1 && c <= `CAD_OP_RTR1) ? r[15:14] : 0;
         cmp("busy", u, k);
         if (k == 20) begin
            end_of_test;
         end
         check_all;
         if (c >= `CAD_OP_STH && c <= `CAD_OP_STAR) begin
            m_scnt = m_scnt + 1;
            cmp("sd", {16'h0, m_sd}, {16'h0, sd});
            cmp("sv", 32'h1, {31'h0, sv});
         end
      end
   endtask
   // Main sequence
   initial begin
      seed = 32'h8e743687;
      err_count = 0;
      samples_checked = 0;
      m_scnt = 0;
      rst_b = 1'b0;
      en = 1'b1;
      {vld, sem, ind, code, rep, src, imod, sh, ssh, sel} = 30'h0;
      {stw, imm, prod} = 64'h0;
      do_reset;
      for (it = 0; it < 100; it = it + 1) begin
         r = $random(seed);
         oc = (it < 19) ? 5'h02 + it[4:0] : 5'h02 + (r[4:0] % 5'h13);
         do_op(`CAD_OP_LOAD, `CAD_SRC_PROD);
         do_op(oc, (oc >= `CAD_OP_LAR) ? `CAD_SRC_IMM : `CAD_SRC_DATA);
      end
      // Held enable low: request and index must not act
      @(posedge clk);
      en <= 1'b0;
      vld <= 1'b1;
      code <= m_cy ? `CAD_OP_CLRCY : `CAD_OP_SETCY;
      ind <= 1'b1;
      imod <= `CAD_IND_INC;
      repeat (3) @(posedge clk);
      en <= 1'b1;
      vld <= 1'b0;
      ind <= 1'b0;
      @(posedge clk);
      #1;
      check_all;
      cmp("cnt", m_scnt, scnt);
      do_reset;
      end_of_test;
   end
endmodule
